//--- include/pmsc_link_if.sv
/*
 * Signals between the serial shifter and the register bank.
 * Assumes frame and count are static while chip select is high,
 * and status is static while a frame is in progress.
 */
`timescale 1ns/100ps
`default_nettype none

interface pmsc_link_if;
    logic [7:0] frame;
    logic [3:0] count;
    logic [7:0] status;

    modport shift (output frame, output count, input status);
    modport ctrl (input frame, input count, output status);
endinterface : pmsc_link_if

`default_nettype wire

//--- include/pmsc_pkg.sv
/*
 * Constants and types shared by the serial control register bank.
 * Assumes a single 20 MHz system clock and an 8-bit serial frame.
 */
`default_nettype none

package pmsc_pkg;

    // ********************************************************
    // Frame layout
    // ********************************************************
    localparam int FRAME_BITS = 8;
    localparam logic [3:0] CNT_FULL = 4'h8;
    localparam logic [3:0] CNT_MAX = 4'h9;
    localparam int TYPE_BIT = 7;
    localparam logic [2:0] ADDR_RUN = 3'h0;
    localparam logic [2:0] ADDR_CHG = 3'h1;
    localparam logic [2:0] ADDR_OV = 3'h2;
    localparam logic [2:0] ADDR_NONE = 3'h3;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int RUN_SEL_BIT = 0;
    localparam int LDO2_BIT = 1;
    localparam int LDO3_BIT = 2;
    localparam int SW1_BIT = 3;
    localparam int SW2_BIT = 4;
    localparam int LOW_CHG_BIT = 0;
    localparam int HIGH_CHG_BIT = 1;
    localparam int BACKUP_BIT = 2;
    localparam int AUTO_BIT = 3;
    localparam int ST_CH2_BIT = 7;
    localparam int ST_CH1_BIT = 6;
    localparam int ST_CH0_BIT = 5;
    localparam int ST_LB_BIT = 4;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [4:0] RUN_RST = 5'h00;
    localparam logic [4:0] CHG_RST = 5'h00;
    localparam logic [4:0] OV_RST = 5'h0c;
    localparam logic [6:0] DAC_RST = 7'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // ********************************************************
    // Synchroniser depth and frame tracker states
    // ********************************************************
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        PMSC_IDLE = 3'b001,
        PMSC_BUSY = 3'b010,
        PMSC_COMMIT = 3'b100
    } pmsc_state_t;

endpackage : pmsc_pkg

`default_nettype wire

//--- rtl/pmsc_regs.sv
/*
 * Serial control register bank of a power management controller.
 * Assumes asynchronous pins for chip select, detectors and modes;
 * the serial clock is a domain of its own handled by the shifter.
 */
// Notes on behaviour
// - Power-on detector holds registers at defaults
// - Reset monitor low reloads all defaults
// - Reset leaves low-power mode until run chosen
// - Eight-bit frame: three address, five data
// - Top bit set: seven-bit DAC code
// - Address 0: switches, regulators, run select
// - Address 1: auto backup, backup, charges
// - Both charge enables pick high current
// - Address 2 voltage code defaults 0x0c
// - Addresses 0, 1 and DAC default zero
// - Backup on disables converter and charging
// - Auto enable plus low battery starts backup
// - Without auto, backup follows backup bit
// - Backup bit overrides charges and auto
// - MSB first, sample rising, shift falling
// - Bit 7 at select, bit 6 later
// - Status: three compares, low battery, rest
// - Compare above DAC reads one; low batt
// - Compare results lag writes by one transfer
// - Run when pin or run bit high
// - Switch 2 needs enable and tone gate
`timescale 1ns/100ps
`default_nettype none

module pmsc_regs (
    input wire logic mclk,
    input wire logic srst,
    input wire logic por_low_out,
    input wire logic reset_monitor_out,
    input wire logic low_batt_flag_out,
    input wire logic run_pin,
    input wire logic tone_gate_in,
    input wire logic channel0_compare,
    input wire logic channel1_compare,
    input wire logic channel2_compare,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic run_mode,
    output logic ldo2_enable,
    output logic ldo3_enable,
    output logic switch1_drive,
    output logic switch2_drive,
    output logic high_charge_on,
    output logic low_charge_on,
    output logic backup_on,
    output logic dcdc_enable,
    output logic dac_enable,
    output logic [4:0] out_voltage_code,
    output logic [6:0] threshold_code
);

    localparam int NSYNC = 9;

    pmsc_link_if link ();

    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync_rst;
    logic [NSYNC-1:0] sync_s;
    logic cs_s;
    logic por_s;
    logic rso_s;
    logic lbo_s;
    logic run_pin_s;
    logic tone_s;
    logic ch0_s;
    logic ch1_s;
    logic ch2_s;
    logic reg_rst;
    logic write_ok;
    pmsc_pkg::pmsc_state_t state_q;
    logic [4:0] run_q;
    logic [4:0] chg_q;
    logic [4:0] ov_q;
    logic [6:0] dac_q;
    logic [7:0] status_q;
    logic backup_d;

    // ********************************************************
    // Serial clock domain
    // ********************************************************
    pmsc_shifter u_shift (
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin),
        .link(link)
    );

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    assign async_in = {cs_n, por_low_out, reset_monitor_out,
        low_batt_flag_out, run_pin, tone_gate_in, channel0_compare,
        channel1_compare, channel2_compare};
    // Idle levels: select high, no reset request, battery fine
    assign sync_rst = {1'b1, 1'b0, 1'b1, 1'b1, 5'h00};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            logic [pmsc_pkg::SYNC_STAGES-1:0] ff_q;
            always_ff @(posedge mclk)
            begin
                if (srst)
                    ff_q <= {pmsc_pkg::SYNC_STAGES{sync_rst[g]}};
                else
                    ff_q <= {ff_q[pmsc_pkg::SYNC_STAGES-2:0], async_in[g]};
            end
            assign sync_s[g] = ff_q[pmsc_pkg::SYNC_STAGES-1];
        end
    endgenerate

    assign {cs_s, por_s, rso_s, lbo_s, run_pin_s, tone_s, ch0_s,
        ch1_s, ch2_s} = sync_s;

    // Any of the three reset sources reloads the defaults
    assign reg_rst = srst | por_s | ~rso_s;

    // ********************************************************
    // Frame tracker
    // ********************************************************
    // Frame and count are read only after select is high again,
    // when the serial clock has stopped and they are static
    always_ff @(posedge mclk)
    begin
        if (srst)
            state_q <= pmsc_pkg::PMSC_IDLE;
        else
        begin
            case (state_q)
                pmsc_pkg::PMSC_IDLE:
                    if (!cs_s)
                        state_q <= pmsc_pkg::PMSC_BUSY;
                pmsc_pkg::PMSC_BUSY:
                    if (cs_s)
                        state_q <= pmsc_pkg::PMSC_COMMIT;
                pmsc_pkg::PMSC_COMMIT:
                    state_q <= pmsc_pkg::PMSC_IDLE;
                default:
                    state_q <= pmsc_pkg::PMSC_IDLE;
            endcase
        end
    end

    // Shorter or longer frames are dropped
    assign write_ok = (state_q == pmsc_pkg::PMSC_COMMIT) &&
        (link.count == pmsc_pkg::CNT_FULL);

    // ********************************************************
    // Control registers
    // ********************************************************
    always_ff @(posedge mclk)
    begin
        if (reg_rst)
        begin
            run_q <= pmsc_pkg::RUN_RST;
            chg_q <= pmsc_pkg::CHG_RST;
            ov_q <= pmsc_pkg::OV_RST;
            dac_q <= pmsc_pkg::DAC_RST;
        end
        else if (write_ok)
        begin
            if (link.frame[pmsc_pkg::TYPE_BIT])
                dac_q <= link.frame[6:0];
            else
            begin
                case (link.frame[7:5])
                    pmsc_pkg::ADDR_RUN:
                        run_q <= link.frame[4:0];
                    pmsc_pkg::ADDR_CHG:
                        chg_q <= {1'b0, link.frame[3:0]};
                    pmsc_pkg::ADDR_OV:
                        ov_q <= link.frame[4:0];
                    default:
                        ; // Address 3 is a dummy write
                endcase
            end
        end
    end

    // ********************************************************
    // Status snapshot
    // ********************************************************
    // Frozen during a frame so the shifter reads a static word;
    // the compare inputs reflect the code of the previous write
    always_ff @(posedge mclk)
    begin
        if (srst)
            status_q <= pmsc_pkg::STATUS_RST;
        else if (state_q == pmsc_pkg::PMSC_IDLE && cs_s)
            status_q <= {ch2_s, ch1_s, ch0_s, ~lbo_s, 4'h0};
    end

    assign link.status = status_q;

    // ********************************************************
    // Output drive
    // ********************************************************
    assign backup_d = chg_q[pmsc_pkg::BACKUP_BIT] |
        (chg_q[pmsc_pkg::AUTO_BIT] & ~lbo_s);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            run_mode <= 1'b0;
            ldo2_enable <= 1'b0;
            ldo3_enable <= 1'b0;
            switch1_drive <= 1'b0;
            switch2_drive <= 1'b0;
            out_voltage_code <= pmsc_pkg::OV_RST;
            threshold_code <= pmsc_pkg::DAC_RST;
            dac_enable <= 1'b0;
        end
        else
        begin
            run_mode <= run_q[pmsc_pkg::RUN_SEL_BIT] | run_pin_s;
            ldo2_enable <= run_q[pmsc_pkg::LDO2_BIT];
            ldo3_enable <= run_q[pmsc_pkg::LDO3_BIT];
            switch1_drive <= run_q[pmsc_pkg::SW1_BIT];
            switch2_drive <= run_q[pmsc_pkg::SW2_BIT] & tone_s;
            out_voltage_code <= ov_q;
            threshold_code <= dac_q;
            // All-zero code powers the comparators down
            dac_enable <= |dac_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            backup_on <= 1'b0;
            dcdc_enable <= 1'b1;
            high_charge_on <= 1'b0;
            low_charge_on <= 1'b0;
        end
        else
        begin
            backup_on <= backup_d;
            dcdc_enable <= ~backup_d;
            high_charge_on <= chg_q[pmsc_pkg::HIGH_CHG_BIT] &
                ~backup_d;
            low_charge_on <= chg_q[pmsc_pkg::LOW_CHG_BIT] &
                ~chg_q[pmsc_pkg::HIGH_CHG_BIT] & ~backup_d;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    chk_por_defaults: assert property (
        por_s |=> (run_q == pmsc_pkg::RUN_RST && chg_q == pmsc_pkg::CHG_RST
        && ov_q == pmsc_pkg::OV_RST && dac_q == pmsc_pkg::DAC_RST))
        else $error("power-on hold did not restore defaults");

    chk_monitor_reload: assert property (
        !rso_s |=> ##1 out_voltage_code == pmsc_pkg::OV_RST
        && (!run_mode || $past(run_pin_s))
        && threshold_code == pmsc_pkg::DAC_RST)
        else $error("reset monitor did not reload defaults");

    chk_short_drop: assert property (
        state_q == pmsc_pkg::PMSC_COMMIT && link.count != 4'h8 && !reg_rst
        |=> $stable(run_q) && $stable(chg_q) && $stable(ov_q)
        && $stable(dac_q))
        else $error("partial frame changed a register");

    chk_dac_load: assert property (
        write_ok && link.frame[7] && !reg_rst
        |=> ##1 threshold_code == $past(link.frame[6:0], 2))
        else $error("DAC frame not loaded");

    chk_addr3_quiet: assert property (
        write_ok && link.frame[7:5] == 3'h3 && !reg_rst
        |=> $stable(run_q) && $stable(chg_q) && $stable(ov_q)
        && $stable(dac_q))
        else $error("address 3 write changed state");

    chk_backup_prio: assert property (
        chg_q[2] |=> backup_on && !dcdc_enable && !high_charge_on
        && !low_charge_on)
        else $error("backup bit did not override");

    chk_charge_pick: assert property (
        chg_q[1:0] == 2'b11 && !backup_d |=> high_charge_on && !low_charge_on)
        else $error("both charge enables not giving high current");

    chk_auto_take: assert property (
        chg_q[3] && !lbo_s |=> backup_on && !dcdc_enable)
        else $error("low battery did not start backup");

    chk_run_or: assert property (
        (run_pin_s || run_q[0]) |=> run_mode)
        else $error("run not selected by pin or bit");

    chk_switch2_gate: assert property (
        !tone_s |=> !switch2_drive)
        else $error("switch 2 on without tone gate");

    chk_status_freeze: assert property (
        state_q == pmsc_pkg::PMSC_BUSY |=> $stable(status_q))
        else $error("status changed during a frame");

    chk_run_write: assert property (
        write_ok && link.frame[7:5] == pmsc_pkg::ADDR_RUN && !reg_rst
        |=> run_q == $past(link.frame[4:0]))
        else $error("address 0 write not stored");

    chk_chg_write: assert property (
        write_ok && link.frame[7:5] == pmsc_pkg::ADDR_CHG && !reg_rst
        |=> chg_q == {1'b0, $past(link.frame[3:0])})
        else $error("address 1 write not stored");

    chk_ov_write: assert property (
        write_ok && link.frame[7:5] == pmsc_pkg::ADDR_OV && !reg_rst
        |=> ov_q == $past(link.frame[4:0]))
        else $error("voltage code write not stored");

    chk_coast_reset: assert property (
        reg_rst |=> !run_q[pmsc_pkg::RUN_SEL_BIT])
        else $error("reset did not leave low-power mode");

    chk_low_batt_status: assert property (
        state_q == pmsc_pkg::PMSC_IDLE && cs_s
        |=> status_q[pmsc_pkg::ST_LB_BIT] == !$past(lbo_s))
        else $error("low battery status bit wrong");

    cov_dac_write: cover property (write_ok && link.frame[7]);
    cov_run_write: cover property (write_ok && link.frame[7:5] == 3'h0);
    cov_short_frame: cover property (
        state_q == pmsc_pkg::PMSC_COMMIT && link.count != 4'h8);
    cov_auto_backup: cover property (chg_q[3] && !lbo_s ##1 backup_on);

endmodule : pmsc_regs

`default_nettype wire

//--- rtl/pmsc_shifter.sv
/*
 * Serial shifter on the serial clock domain.
 * Assumes the host keeps the serial clock low and still while chip
 * select is high, and gives setup before the first rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module pmsc_shifter (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    pmsc_link_if.shift link
);

    logic fresh_q;
    logic fell_q;
    logic sdo_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic [2:0] idx;

    // ********************************************************
    // Frame start marker
    // ********************************************************
    // Chip select high arms a new frame without needing clock edges
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            fresh_q <= 1'b1;
        else
            fresh_q <= 1'b0;
    end

    // ********************************************************
    // Input shift, MSB first on rising edge
    // ********************************************************
    // Shift and count are not cleared at frame end: the bank reads them
    always_ff @(posedge sclk)
    begin
        if (fresh_q)
        begin
            shift_q <= {7'h00, serial_in_pin};
            cnt_q <= 4'h1;
        end
        else
        begin
            shift_q <= {shift_q[6:0], serial_in_pin};
            if (cnt_q != pmsc_pkg::CNT_MAX)
                cnt_q <= cnt_q + 4'h1;
        end
    end

    // ********************************************************
    // Output shift on falling edge
    // ********************************************************
    assign idx = 3'(4'h7 - cnt_q);

    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            fell_q <= 1'b0;
            sdo_q <= 1'b0;
        end
        else
        begin
            fell_q <= 1'b1;
            sdo_q <= (cnt_q < pmsc_pkg::CNT_FULL) ? link.status[idx]
                : 1'b0;
        end
    end

    // Bit 7 must show before any clock edge, hence the select
    assign serial_out_pin = fell_q ? sdo_q : link.status[7];
    assign link.frame = shift_q;
    assign link.count = cnt_q;

endmodule : pmsc_shifter

`default_nettype wire

//--- sim/pmic_serial_control_regs_tb.sv
/*
 * Self-checking bench for the serial control register bank.
 * Assumes the host model in pmsc_host and the design's 20 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pmic_serial_control_regs_tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic por_low_out = 1'b0;
    logic reset_monitor_out = 1'b1;
    logic low_batt_flag_out = 1'b1;
    logic run_pin = 1'b0;
    logic tone_gate_in = 1'b0;
    logic [2:0] chan = 3'h0;
    wire logic sclk, cs_n, serial_in_pin, serial_out_pin;
    wire logic run_mode, ldo2_enable, ldo3_enable, dcdc_enable, dac_enable;
    wire logic switch1_drive, switch2_drive, backup_on;
    wire logic high_charge_on, low_charge_on;
    wire logic [4:0] out_voltage_code;
    wire logic [6:0] threshold_code;
    wire logic [7:0] pw;
    wire logic [7:0] cg;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] rx;

    assign pw = {3'h0, switch2_drive, switch1_drive, ldo3_enable,
        ldo2_enable, run_mode};
    assign cg = {4'h0, dcdc_enable, backup_on, high_charge_on,
        low_charge_on};

    always #25 mclk = ~mclk;

    pmsc_regs uut (.mclk(mclk), .srst(srst), .por_low_out(por_low_out),
        .reset_monitor_out(reset_monitor_out),
        .low_batt_flag_out(low_batt_flag_out), .run_pin(run_pin),
        .tone_gate_in(tone_gate_in), .channel0_compare(chan[0]),
        .channel1_compare(chan[1]), .channel2_compare(chan[2]),
        .sclk(sclk), .cs_n(cs_n), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .run_mode(run_mode),
        .ldo2_enable(ldo2_enable), .ldo3_enable(ldo3_enable),
        .switch1_drive(switch1_drive), .switch2_drive(switch2_drive),
        .high_charge_on(high_charge_on), .low_charge_on(low_charge_on),
        .backup_on(backup_on), .dcdc_enable(dcdc_enable),
        .dac_enable(dac_enable), .out_voltage_code(out_voltage_code),
        .threshold_code(threshold_code));

    pmsc_host host (.sclk(sclk), .cs_n(cs_n),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n

    // Eight settle cycles cover commit latency and frame spacing
    task automatic wr(input logic [7:0] b);
        host.xfer(b, 8, rx);
        wait_n(8);
    endtask : wr

    task automatic chk_defaults();
        check(pw, 8'h00);
        check(cg, 8'h08);
        check({3'h0, out_voltage_code}, 8'h0c);
        check({dac_enable, threshold_code}, 8'h00);
    endtask : chk_defaults

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fails++;
            finish_test();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_run_reg();
        wr(8'h1f);
        check(pw, 8'h0f);
        tone_gate_in = 1'b1;
        wait_n(6);
        check(pw, 8'h1f);
        wr(8'h00);
        check(pw, 8'h00);
        run_pin = 1'b1;
        wait_n(6);
        check(pw, 8'h01);
        run_pin = 1'b0;
        wait_n(6);
        check(pw, 8'h00);
    endtask : t_run_reg

    task automatic t_charge();
        wr(8'h23);
        check(cg, 8'h0a);
        wr(8'h21);
        check(cg, 8'h09);
        wr(8'h24);
        check(cg, 8'h04);
        wr(8'h28);
        check(cg, 8'h08);
        low_batt_flag_out = 1'b0;
        wait_n(6);
        check(cg, 8'h04);
        low_batt_flag_out = 1'b1;
        wait_n(6);
        check(cg, 8'h08);
        wr(8'h2f);
        check(cg, 8'h04);
        wr(8'h30);
        check(cg, 8'h08);
    endtask : t_charge

    task automatic t_ov_dac();
        wr(8'h5f);
        check({3'h0, out_voltage_code}, 8'h1f);
        wr(8'h7f);
        check({3'h0, out_voltage_code}, 8'h1f);
        check(cg, 8'h08);
        wr(8'h85);
        check({dac_enable, threshold_code}, 8'h85);
        check({3'h0, out_voltage_code}, 8'h1f);
        host.xfer(8'h40, 7, rx);
        wait_n(8);
        check({3'h0, out_voltage_code}, 8'h1f);
    endtask : t_ov_dac

    task automatic t_status();
        chan = 3'b101;
        low_batt_flag_out = 1'b0;
        wait_n(8);
        wr(8'h7f);
        check(rx, 8'hb0);
        chan = 3'b010;
        low_batt_flag_out = 1'b1;
        wait_n(8);
        wr(8'h7f);
        check(rx, 8'h40);
    endtask : t_status

    task automatic t_resets();
        wr(8'h1f);
        reset_monitor_out = 1'b0;
        wait_n(6);
        reset_monitor_out = 1'b1;
        wait_n(6);
        chk_defaults();
        wr(8'h1f);
        wr(8'h4a);
        por_low_out = 1'b1;
        wait_n(6);
        chk_defaults();
        por_low_out = 1'b0;
        wait_n(6);
        chk_defaults();
    endtask : t_resets

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        wait_n(4);
        srst = 1'b0;
        wait_n(4);
        chk_defaults();
        t_run_reg();
        t_charge();
        t_ov_dac();
        t_status();
        t_resets();
        finish_test();
    end
endmodule : pmic_serial_control_regs_tb

`default_nettype wire

//--- sim/pmsc_host.sv
/*
 * Host model: serial bus master for the control register bank.
 * Assumes the bench calls xfer with chip select idle and spacing kept.
 */
`timescale 1ns/100ps
`default_nettype none

module pmsc_host (
    output logic sclk,
    output logic cs_n,
    output logic serial_in_pin,
    input wire logic serial_out_pin
);
    // ****************************************
    // Transfer
    // ****************************************
    initial
    begin
        sclk = 1'b0;
        serial_in_pin = 1'b0;
        // Late select rise, so the shifter sees an edge and arms
        #1 cs_n = 1'b1;
    end

    // Clock runs only inside frames; released data line is inverted
    task automatic xfer(input logic [7:0] tx, input int nbits,
        output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        #211;
        for (int i = 0; i < nbits; i++)
        begin
            serial_in_pin = tx[7 - i];
            #8 rx = {rx[6:0], serial_out_pin};
            #8 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        serial_in_pin = ~serial_in_pin;
    endtask : xfer
endmodule : pmsc_host

`default_nettype wire
